/* File: pkg/cwce_defines.svh */
// Behaviour
// - cmpsub: no underflow, write D-S, carry 1
// - cmpsub: underflow, D unchanged, carry 0
// - wait stalls, rechecks each cycle, then proceeds
// - stalled wait gates unneeded execution logic
// - pin waits mask input pins with S
// - equal/not-equal pin compare against D
// - global 32-bit counter increments every clock out of reset, held at 0 during reset
// - counter wait until equal, then D+=S
// - exact equality only, missed target waits wrap
// - video samples D,S whenever ready; completes handoff
// - video handoff hangs if peripheral not running
`ifndef CWCE_DEFINES_SVH
`define CWCE_DEFINES_SVH
`define CWCE_WORD_W 32
`define CWCE_CNT_RST 32'h00000000
`define CWCE_OP_W 3
`endif

/* File: pkg/cwce_pkg.sv */
package cwce_pkg;
  typedef enum logic [2:0] {
    CWCE_OP_NONE,
    CWCE_OP_CMPSUB,
    CWCE_OP_PEQ,
    CWCE_OP_PNE,
    CWCE_OP_CNT,
    CWCE_OP_VID
  } cwce_op_t;
  typedef enum logic [1:0] {
    CWCE_IDLE,
    CWCE_WAIT
  } cwce_state_t;
endpackage : cwce_pkg

/* File: src/cwce_exec.sv */
`timescale 1ns/1ps
`include "cwce_defines.svh"
module cwce_exec #(
  parameter int W = `CWCE_WORD_W
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Instruction issue
  input wire logic issue_i,
  input wire cwce_pkg::cwce_op_t op_i,
  input wire logic [W-1:0] d_i,
  input wire logic [W-1:0] s_i,
  output logic busy_o,
  output logic done_o,
  output logic wr_en_o,
  output logic [W-1:0] wr_data_o,
  output logic carry_wr_o,
  output logic carry_o,
  output logic exec_gate_o,
  // Pins
  input wire logic [W-1:0] input_pin_states_i,
  // System counter
  output logic [W-1:0] system_counter_o,
  // Video peripheral
  input wire logic vid_ready_i,
  output logic vid_take_o,
  output logic [W-1:0] vid_colour_o,
  output logic [W-1:0] vid_pixel_o
);
  import cwce_pkg::*;

  logic [W-1:0] pin_s1_q, pin_s2_q;
  logic [W-1:0] cnt_q;
  cwce_state_t state_q;
  cwce_op_t op_q;
  logic [W-1:0] d_q, s_q;
  logic hit;
  logic [W:0] diff;

  function automatic logic [W-1:0] wrap_add(input logic [W-1:0] a, input logic [W-1:0] b);
    logic [W:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    return sum[W-1:0];
  endfunction : wrap_add

  always_ff @(posedge clock_i) begin
    pin_s1_q <= input_pin_states_i;
    pin_s2_q <= pin_s1_q;
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) cnt_q <= W'(`CWCE_CNT_RST);
    else cnt_q <= wrap_add(cnt_q, {{(W-1){1'b0}}, 1'b1});
  end
  assign system_counter_o = cnt_q;

  // Condition for the held wait
  always_comb begin
    unique case (op_q)
      CWCE_OP_PEQ: hit = ((pin_s2_q & s_q) == d_q);
      CWCE_OP_PNE: hit = ((pin_s2_q & s_q) != d_q);
      CWCE_OP_CNT: hit = (cnt_q == d_q);
      CWCE_OP_VID: hit = vid_ready_i;
      default: hit = 1'b0;
    endcase
  end

  assign diff = {1'b0, d_i} - {1'b0, s_i};
  assign busy_o = (state_q == CWCE_WAIT);
  assign exec_gate_o = ~busy_o;
  assign vid_take_o = vid_ready_i;

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      state_q <= CWCE_IDLE;
      op_q <= CWCE_OP_NONE;
      d_q <= '0;
      s_q <= '0;
    end else if (state_q == CWCE_IDLE) begin
      // Unused op codes are ignored, so they cannot stall forever
      if (issue_i && (op_i inside {CWCE_OP_PEQ, CWCE_OP_PNE, CWCE_OP_CNT, CWCE_OP_VID})) begin
        state_q <= CWCE_WAIT;
        op_q <= op_i;
        d_q <= d_i;
        s_q <= s_i;
      end
    end else if (hit) begin
      state_q <= CWCE_IDLE;
      op_q <= CWCE_OP_NONE;
    end
  end

  // Results
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      done_o <= 1'b0;
      wr_en_o <= 1'b0;
      wr_data_o <= '0;
      carry_wr_o <= 1'b0;
      carry_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      wr_en_o <= 1'b0;
      carry_wr_o <= 1'b0;
      if (state_q == CWCE_IDLE && issue_i && op_i == CWCE_OP_CMPSUB) begin
        done_o <= 1'b1;
        carry_wr_o <= 1'b1;
        carry_o <= ~diff[W];
        wr_en_o <= ~diff[W];
        wr_data_o <= diff[W-1:0];
      end else if (busy_o && hit) begin
        done_o <= 1'b1;
        if (op_q == CWCE_OP_CNT) begin
          wr_en_o <= 1'b1;
          wr_data_o <= wrap_add(d_q, s_q);
        end
      end
    end
  end

  // Video sample: held operands of any pending wait, else the current d_i and s_i inputs
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      vid_colour_o <= '0;
      vid_pixel_o <= '0;
    end else if (vid_ready_i) begin
      vid_colour_o <= busy_o ? d_q : d_i;
      vid_pixel_o <= busy_o ? s_q : s_i;
    end
  end

  property p_cmpsub_ok;
    @(posedge clock_i) disable iff (!nrst_i)
      (!busy_o && issue_i && op_i == CWCE_OP_CMPSUB && d_i >= s_i)
      |=> (carry_o && wr_en_o && wr_data_o == $past(d_i) - $past(s_i));
  endproperty
  a_cmpsub_ok: assert property (p_cmpsub_ok) else $error("cmpsub result wrong");

  property p_cmpsub_uf;
    @(posedge clock_i) disable iff (!nrst_i)
      (!busy_o && issue_i && op_i == CWCE_OP_CMPSUB && d_i < s_i) |=> (!carry_o && !wr_en_o);
  endproperty
  a_cmpsub_uf: assert property (p_cmpsub_uf) else $error("cmpsub underflow wrote");

  property p_wait_done;
    @(posedge clock_i) disable iff (!nrst_i)
      (busy_o && hit) |=> (done_o && !busy_o);
  endproperty
  a_wait_done: assert property (p_wait_done) else $error("wait did not finish");

  property p_wait_hold;
    @(posedge clock_i) disable iff (!nrst_i)
      (busy_o && !hit) |=> (busy_o && !done_o);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("wait left early");

  property p_gate;
    @(posedge clock_i) disable iff (!nrst_i) busy_o |-> !exec_gate_o;
  endproperty
  a_gate: assert property (p_gate) else $error("exec not gated");

  property p_pins;
    @(posedge clock_i) disable iff (!nrst_i)
      (busy_o && op_q == CWCE_OP_PEQ && (pin_s2_q & s_q) != d_q) |=> busy_o;
  endproperty
  a_pins: assert property (p_pins) else $error("pin wait ended on mismatch");

  property p_cnt;
    @(posedge clock_i) disable iff (!nrst_i)
      nrst_i |=> system_counter_o == $past(system_counter_o) + W'(1);
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter not incrementing");

  property p_cnt_wr;
    @(posedge clock_i) disable iff (!nrst_i)
      (busy_o && op_q == CWCE_OP_CNT && cnt_q == d_q) |=> (wr_en_o && wr_data_o == $past(d_q) + $past(s_q));
  endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("counter wait writeback wrong");

  property p_vid;
    @(posedge clock_i) disable iff (!nrst_i)
      (busy_o && op_q == CWCE_OP_VID && vid_ready_i) |=> (vid_colour_o == $past(d_q) && done_o);
  endproperty
  a_vid: assert property (p_vid) else $error("video handoff wrong");

  property p_vid_pix;
    @(posedge clock_i) disable iff (!nrst_i)
      (busy_o && op_q == CWCE_OP_VID && vid_ready_i) |=> (vid_pixel_o == $past(s_q));
  endproperty
  a_vid_pix: assert property (p_vid_pix) else $error("video pixel word wrong");

  property p_vid_hang;
    @(posedge clock_i) disable iff (!nrst_i)
      (busy_o && op_q == CWCE_OP_VID && !vid_ready_i) |=> (busy_o && !done_o);
  endproperty
  a_vid_hang: assert property (p_vid_hang) else $error("video wait ended early");

  property p_pne_hold;
    @(posedge clock_i) disable iff (!nrst_i)
      (busy_o && op_q == CWCE_OP_PNE && (pin_s2_q & s_q) == d_q) |=> busy_o;
  endproperty
  a_pne_hold: assert property (p_pne_hold) else $error("pin wait ended on match");

  property p_peq_done;
    @(posedge clock_i) disable iff (!nrst_i)
      (busy_o && op_q == CWCE_OP_PEQ && (pin_s2_q & s_q) == d_q) |=> (done_o && !busy_o);
  endproperty
  a_peq_done: assert property (p_peq_done) else $error("masked pin match missed");

  property p_cnt_miss;
    @(posedge clock_i) disable iff (!nrst_i)
      (busy_o && op_q == CWCE_OP_CNT && cnt_q != d_q) |=> (busy_o && !wr_en_o);
  endproperty
  a_cnt_miss: assert property (p_cnt_miss) else $error("counter wait ended off target");

  property p_cnt_flags;
    @(posedge clock_i) disable iff (!nrst_i)
      (busy_o && op_q == CWCE_OP_CNT && hit) |=> (done_o && !carry_wr_o);
  endproperty
  a_cnt_flags: assert property (p_cnt_flags) else $error("counter wait touched carry");

  property p_cmpsub_cw;
    @(posedge clock_i) disable iff (!nrst_i)
      (!busy_o && issue_i && op_i == CWCE_OP_CMPSUB) |=> (carry_wr_o && done_o && !busy_o);
  endproperty
  a_cmpsub_cw: assert property (p_cmpsub_cw) else $error("cmpsub carry not written");

  property p_gate_idle;
    @(posedge clock_i) disable iff (!nrst_i) !busy_o |-> exec_gate_o;
  endproperty
  a_gate_idle: assert property (p_gate_idle) else $error("exec gated while idle");

  // Reset stops the core and clears the counter
  property p_reset;
    @(posedge clock_i)
      !nrst_i |=> (!busy_o && !done_o && !wr_en_o && system_counter_o == '0);
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not stop core");
endmodule : cwce_exec

/* File: tb/cwce_far_model.sv */
`timescale 1ns/1ps
module cwce_far_model (
  // Bench side
  input wire logic clock_i,
  input wire logic run_i,
  input wire logic [31:0] pins_val_i,
  // Core side
  output logic vid_ready_o,
  output logic [31:0] pins_o
);
  logic [1:0] div_q = 2'h0;
  always_ff @(posedge clock_i) begin
    div_q <= div_q + 2'h1;
  end
  // Pickup every fourth cycle while running
  assign vid_ready_o = run_i && (div_q == 2'h3);
  assign pins_o = pins_val_i;
endmodule : cwce_far_model

/* File: tb/tb_cwce_exec.sv */
`timescale 1ns/1ps
module tb_cwce_exec;
  import cwce_pkg::*;
  logic clock_i, nrst_i = 0, issue_i = 0, busy_o, done_o, wr_en_o, carry_o, run = 0, rdy;
  logic cw, gate, take;
  cwce_op_t op_i = CWCE_OP_NONE;
  logic [31:0] d_i = 0, s_i = 0, pv = 0, pins, wr_data_o, cnt_o, col_o, pix_o, c;
  int failures = 0, n_checks = 0;
  cwce_exec DUT (.clock_i(clock_i), .nrst_i(nrst_i), .issue_i(issue_i), .op_i(op_i),
    .d_i(d_i), .s_i(s_i), .busy_o(busy_o), .done_o(done_o), .wr_en_o(wr_en_o),
    .wr_data_o(wr_data_o), .carry_wr_o(cw), .carry_o(carry_o), .exec_gate_o(gate),
    .input_pin_states_i(pins), .system_counter_o(cnt_o), .vid_ready_i(rdy),
    .vid_take_o(take), .vid_colour_o(col_o), .vid_pixel_o(pix_o));
  cwce_far_model far (.clock_i(clock_i), .run_i(run), .pins_val_i(pv),
    .vid_ready_o(rdy), .pins_o(pins));
  initial begin
    clock_i = 0;
    forever #25 clock_i = ~clock_i;
  end
  task chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task issue(input cwce_op_t o, input logic [31:0] d, input logic [31:0] s);
    @(posedge clock_i);
    issue_i <= 1;
    op_i <= o;
    d_i <= d;
    s_i <= s;
    @(posedge clock_i);
    issue_i <= 0;
  endtask : issue
  task wait_done(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      #1;
      if (done_o === 1'b1) break;
      @(posedge clock_i);
    end
    chk(i < n, "no finish");
  endtask : wait_done
  task t_cmp(input logic [31:0] d, input logic [31:0] s);
    issue(CWCE_OP_CMPSUB, d, s);
    wait_done(4);
    chk(carry_o === (d >= s) && wr_en_o === (d >= s), "carry");
    chk(cw === 1'b1 && busy_o === 1'b0, "carry write");
    if (d >= s) chk(wr_data_o === d - s, "diff");
  endtask : t_cmp
  task t_pins;
    @(posedge clock_i);
    pv <= 32'hA5;
    issue(CWCE_OP_PEQ, 32'h5, 32'hF);
    wait_done(8);
    issue(CWCE_OP_PNE, 32'h5, 32'hF);
    repeat (10) @(posedge clock_i);
    #1 chk(busy_o === 1'b1 && gate === 1'b0, "pne stall");
    @(posedge clock_i);
    pv <= 32'hF5;
    repeat (6) @(posedge clock_i);
    #1 chk(busy_o === 1'b1 && done_o === 1'b0, "pne masked");
    @(posedge clock_i);
    pv <= 32'hA6;
    wait_done(8);
    chk(gate === 1'b1 && wr_en_o === 1'b0, "pne resume");
  endtask : t_pins
  task t_cnt;
    #1 c = cnt_o;
    @(posedge clock_i);
    #1 chk(cnt_o === c + 32'h1, "count");
    issue(CWCE_OP_CNT, c + 32'h14, 32'hFFFFFFF0);
    wait_done(30);
    chk(wr_en_o === 1'b1 && wr_data_o === c + 32'h4, "target");
  endtask : t_cnt
  task t_vid;
    issue(CWCE_OP_VID, 32'hC0105, 32'h9A7E);
    repeat (12) @(posedge clock_i);
    #1 chk(busy_o === 1'b1 && take === 1'b0, "vid hang");
    @(posedge clock_i);
    run <= 1;
    @(posedge rdy);
    #1 chk(take === 1'b1 && busy_o === 1'b1, "vid take");
    wait_done(4);
    run <= 0;
    @(posedge clock_i);
    #1 chk(col_o === 32'hC0105 && pix_o === 32'h9A7E, "vid data");
  endtask : t_vid
  task t_miss;
    issue(CWCE_OP_CNT, cnt_o - 32'h8, 32'h1);
    repeat (40) @(posedge clock_i);
    #1 chk(busy_o === 1'b1 && done_o === 1'b0, "missed target");
    @(posedge clock_i);
    nrst_i <= 0;
    repeat (2) @(posedge clock_i);
    #1 chk(busy_o === 1'b0 && cnt_o === 32'h0 && col_o === 32'h0, "reset");
    @(posedge clock_i);
    nrst_i <= 1;
    #1 chk(cnt_o === 32'h0, "count hold");
    @(posedge clock_i);
    #1 chk(cnt_o === 32'h1, "count start");
    t_cmp(32'h10, 32'h1);
  endtask : t_miss
  task give_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (10) @(posedge clock_i);
    nrst_i <= 1;
    t_cmp(32'hA, 32'h3);
    t_cmp(32'h3, 32'hA);
    t_cmp(32'h7, 32'h7);
    $display("cmpsub done");
    t_pins;
    $display("pins done");
    t_cnt;
    $display("counter done");
    t_vid;
    $display("video done");
    t_miss;
    $display("reset done");
    give_verdict;
  end
  initial begin
    #150000;
    failures++;
    give_verdict;
  end
endmodule : tb_cwce_exec
